// *** fptr_pkg.sv ***
// Purpose: Constants, carriers and table lookup for the parameter table ROM
// Assumes: Relative byte addresses are 12 bits wide
// Notes:   Bytes outside the covered span read as all ones
package fptr_pkg;

   localparam int          ADDR_W        = 12;
   localparam logic [11:0] TBL_FIRST     = 12'h310;
   localparam logic [11:0] TBL_LAST      = 12'h324;
   localparam logic [11:0] PTR_RESET     = 12'h310;
   localparam logic [11:0] PTR_STEP      = 12'h001;

   // APB byte offsets
   localparam logic [11:0] OFS_ADDR      = 12'h000;
   localparam logic [11:0] OFS_DATA      = 12'h004;
   localparam logic [11:0] OFS_STAT      = 12'h008;

   localparam logic [7:0]  BYTE_ONES     = 8'hff;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [7:0]  BYTE_CAPS     = 8'hfe;
   localparam logic [7:0]  BYTE_QCYC     = 8'h48;
   localparam logic [7:0]  BYTE_QOPC     = 8'heb;
   localparam logic [7:0]  BYTE_SECT_SZ  = 8'h14;
   localparam logic [7:0]  BYTE_SECT_OPC = 8'h20;
   localparam logic [7:0]  BYTE_BLK_SZ   = 8'h17;
   localparam logic [7:0]  BYTE_BLK_OPC  = 8'hd8;
   localparam logic [7:0]  BYTE_ETIME    = 8'ha0;

   localparam int          STAT_INRANGE  = 0;

   typedef struct packed {
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } fptr_req_s;

   function automatic logic [7:0] table_byte(input logic [11:0] a);
      logic [7:0] v;
      v = BYTE_ONES;
      case (a)
         12'h310: v = BYTE_CAPS;
         12'h316: v = BYTE_ZERO;
         12'h31a: v = BYTE_QCYC;
         12'h31b: v = BYTE_QOPC;
         12'h31c: v = BYTE_SECT_SZ;
         12'h31d: v = BYTE_SECT_OPC;
         12'h31e: v = BYTE_BLK_SZ;
         12'h31f: v = BYTE_BLK_OPC;
         12'h320: v = BYTE_ZERO;
         12'h322: v = BYTE_ZERO;
         12'h324: v = BYTE_ETIME;
         default: v = BYTE_ONES;
      endcase
      return v;
   endfunction

   function automatic logic in_table(input logic [11:0] a);
      return (a >= TBL_FIRST) && (a <= TBL_LAST);
   endfunction

endpackage

// *** fptr_rom.sv ***
// Purpose: APB-readable parameter table with auto-advancing byte pointer
// Assumes: One clock, synchronous inputs, 32-bit APB data
// Notes:   Every access answers with one wait state while CE stays high
`timescale 1ns/1ps
module fptr_rom #(
   parameter int AW = fptr_pkg::ADDR_W
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR
);

   if (AW != fptr_pkg::ADDR_W) begin : g_bad_aw
      $error("AW must equal the relative address width");
   end

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } fptr_st_e;

   fptr_pkg::fptr_req_s req;
   fptr_st_e            st_ff;
   fptr_st_e            nxt_st;
   logic [11:0]         ptr_ff;
   logic [11:0]         nxt_ptr;
   logic                start;
   logic                rd_data;
   logic                wr_addr;

   assign req     = '{write: PWRITE, addr: PADDR, wdata: PWDATA};
   assign start   = PSEL && PENABLE && (st_ff == ST_IDLE);
   assign rd_data = start && !req.write && (req.addr == fptr_pkg::OFS_DATA);
   assign wr_addr = start && req.write && (req.addr == fptr_pkg::OFS_ADDR);

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: if (start) nxt_st = ST_DONE;
         ST_DONE: nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_ff <= ST_IDLE;
      end else if (CE) begin
         st_ff <= nxt_st;
      end
   end

   always_comb begin
      nxt_ptr = ptr_ff;
      if (wr_addr) begin
         nxt_ptr = req.wdata[11:0];
      end else if (rd_data) begin
         nxt_ptr = ptr_ff + fptr_pkg::PTR_STEP;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ptr_ff <= fptr_pkg::PTR_RESET;
      end else if (CE) begin
         ptr_ff <= nxt_ptr;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PREADY <= 1'b0;
      end else if (CE) begin
         PREADY <= (nxt_st == ST_DONE);
      end
   end

   // Read data and error are loaded in the cycle that raises PREADY
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PRDATA  <= '0;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         if (start) begin
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
            case (req.addr)
               fptr_pkg::OFS_ADDR: begin
                  if (!req.write) PRDATA <= {20'h00000, ptr_ff};
               end
               fptr_pkg::OFS_DATA: begin
                  if (req.write) begin
                     PSLVERR <= 1'b1;
                  end else begin
                     PRDATA <= {24'h000000, fptr_pkg::table_byte(ptr_ff)};
                  end
               end
               fptr_pkg::OFS_STAT: begin
                  if (req.write) begin
                     PSLVERR <= 1'b1;
                  end else begin
                     PRDATA[fptr_pkg::STAT_INRANGE] <=
                        fptr_pkg::in_table(ptr_ff);
                  end
               end
               default: PSLVERR <= 1'b1;
            endcase
         end else if (st_ff == ST_DONE) begin
            PSLVERR <= 1'b0;
         end
      end
   end

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   property p_caps;
      CE && rd_data && ptr_ff == 12'h310 |=> PRDATA[7:0] == 8'hfe;
   endproperty
   a_caps: assert property (p_caps)
      else $error("byte 310h wrong");

   property p_rsvd;
      CE && rd_data && (ptr_ff inside {12'h311, 12'h312, 12'h313, 12'h314,
         12'h315, 12'h318, 12'h319}) |=> PRDATA == 32'h000000ff;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved byte not FFh");

   property p_dual;
      CE && rd_data && (ptr_ff == 12'h316 || ptr_ff == 12'h317)
         |=> PRDATA == ($past(ptr_ff[0]) ? 32'h000000ff : 32'h00000000);
   endproperty
   a_dual: assert property (p_dual)
      else $error("2-2-2 bytes wrong");

   property p_qcyc;
      CE && rd_data && ptr_ff == 12'h31a
         |=> PRDATA[7:5] == 3'h2 && PRDATA[4:0] == 5'h08;
   endproperty
   a_qcyc: assert property (p_qcyc)
      else $error("mode or dummy count wrong");

   property p_qopc;
      CE && rd_data && ptr_ff == 12'h31b |=> PRDATA[7:0] == 8'heb;
   endproperty
   a_qopc: assert property (p_qopc)
      else $error("quad opcode wrong");

   property p_sect;
      CE && rd_data && (ptr_ff == 12'h31c || ptr_ff == 12'h31d)
         |=> PRDATA[7:0] == ($past(ptr_ff[0]) ? 8'h20 : 8'h14);
   endproperty
   a_sect: assert property (p_sect)
      else $error("sector erase bytes wrong");

   property p_blk;
      CE && rd_data && (ptr_ff == 12'h31e || ptr_ff == 12'h31f)
         |=> PRDATA[7:0] == ($past(ptr_ff[0]) ? 8'hd8 : 8'h17);
   endproperty
   a_blk: assert property (p_blk)
      else $error("block erase bytes wrong");

   property p_noer;
      CE && rd_data && (ptr_ff inside {12'h320, 12'h321, 12'h322, 12'h323})
         |=> PRDATA[7:0] == ($past(ptr_ff[0]) ? 8'hff : 8'h00);
   endproperty
   a_noer: assert property (p_noer)
      else $error("unsupported erase bytes wrong");

   property p_etime;
      CE && rd_data && ptr_ff == 12'h324 |=> PRDATA[7:0] == 8'ha0;
   endproperty
   a_etime: assert property (p_etime)
      else $error("byte 324h wrong");

   property p_adv;
      CE && rd_data |=> ptr_ff == $past(ptr_ff) + 12'h001;
   endproperty
   a_adv: assert property (p_adv)
      else $error("pointer did not advance");

   property p_load;
      CE && wr_addr |=> ptr_ff == $past(PWDATA[11:0]);
   endproperty
   a_load: assert property (p_load)
      else $error("pointer not loaded");

   property p_ready;
      CE && start |=> PREADY ##1 (!PREADY || !$past(CE));
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready timing wrong");

   c_load: cover property (CE && wr_addr);
   c_burst: cover property (CE && rd_data ##4 CE && rd_data ##4 CE && rd_data);
   c_err: cover property (PREADY && PSLVERR);

endmodule // fptr_rom

// *** fptr_host.sv ***
// Purpose: APB host model that walks the parameter table
// Assumes: One access at a time; the bench watchdog ends a hung wait
// Notes:   After their blocking time-zero values, signals change only by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module fptr_host (
   input  wire logic         clk,
   input  wire logic         pready,
   input  wire logic  [31:0] prdata,
   input  wire logic         pslverr,
   output logic              psel,
   output logic              penable,
   output fptr_pkg::fptr_req_s req
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      req     = '0;
   end

   // One APB access, read or write: setup phase, then access phase until PREADY is seen high
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      req     <= '{write: w, addr: a, wdata: d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // fptr_host

// *** tb_flash_parameter_table_rom.sv ***
// Purpose: Self-checking bench for the parameter table ROM
// Assumes: Reset pointer and register offsets as in the package
// Notes:   Expected bytes are kept here, apart from the design
`timescale 1ns/1ps
module tb_flash_parameter_table_rom;
   logic                CLK, RST, CE, PSEL, PENABLE, PREADY, PSLVERR;
   logic         [31:0] PRDATA, rd;
   logic                er;
   fptr_pkg::fptr_req_s req;
   int                  err_total, tests_run;
   localparam logic [7:0] EXP [21] = '{8'hfe, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h48, 8'heb, 8'h14,
      8'h20, 8'h17, 8'hd8, 8'h00, 8'hff, 8'h00, 8'hff, 8'ha0};

   fptr_rom i_fptr_rom (.CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(req.write), .PADDR(req.addr),
      .PWDATA(req.wdata), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR));
   fptr_host i_fptr_host (.clk(CLK), .pready(PREADY), .prdata(PRDATA),
      .pslverr(PSLVERR), .psel(PSEL), .penable(PENABLE), .req(req));

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic acc(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic exp_er);
      i_fptr_host.xfer(w, a, d, rd, er);
      chk("slave error", {31'h0, er}, {31'h0, exp_er});
   endtask

   task automatic rd_bytes(input int first, input int n);
      for (int i = 0; i < n; i++) begin
         acc(1'b0, fptr_pkg::OFS_DATA, 32'h0, 1'b0);
         chk("table byte", rd, {24'h0, EXP[first+i]});
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   initial begin
      repeat (2000) @(posedge CLK);
      err_total++;
      results();
   end

   initial begin
      err_total = 0;
      tests_run = 0;
      RST = 1'b1;
      CE  = 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      rd_bytes(0, 1);
      rd_bytes(1, 9);
      acc(1'b1, fptr_pkg::OFS_ADDR, 32'h31a, 1'b0);
      rd_bytes(10, 1);
      rd_bytes(11, 1);
      rd_bytes(12, 4);
      rd_bytes(16, 5);
      acc(1'b0, fptr_pkg::OFS_ADDR, 32'h0, 1'b0);
      chk("pointer", rd, 32'h325);
      acc(1'b0, fptr_pkg::OFS_STAT, 32'h0, 1'b0);
      chk("in range", {31'h0, rd[0]}, 32'h0);
      acc(1'b1, fptr_pkg::OFS_ADDR, 32'h324, 1'b0);
      acc(1'b0, fptr_pkg::OFS_STAT, 32'h0, 1'b0);
      chk("in range", {31'h0, rd[0]}, 32'h1);
      acc(1'b1, fptr_pkg::OFS_DATA, 32'h55, 1'b1);
      acc(1'b0, 12'h00c, 32'h0, 1'b1);
      rd_bytes(20, 1);
      acc(1'b1, fptr_pkg::OFS_ADDR, 32'h310, 1'b0);
      rd_bytes(0, 2);
      // Clock enable low for three edges in the middle of a read
      acc(1'b1, fptr_pkg::OFS_ADDR, 32'h31b, 1'b0);
      fork
         rd_bytes(11, 1);
         begin
            repeat (2) @(posedge CLK);
            CE <= 1'b0;
            repeat (3) @(posedge CLK);
            CE <= 1'b1;
         end
      join
      acc(1'b0, fptr_pkg::OFS_ADDR, 32'h0, 1'b0);
      chk("pointer", rd, 32'h31c);
      // Second reset in mid-run returns the pointer to its start
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      acc(1'b0, fptr_pkg::OFS_ADDR, 32'h0, 1'b0);
      chk("pointer", rd, 32'h310);
      rd_bytes(0, 1);
      results();
   end
endmodule // tb_flash_parameter_table_rom
